// *** verilog/qtu_map.svh ***
// register offsets, field positions and option-word encodings
`ifndef QTU_MAP_SVH
`define QTU_MAP_SVH
// quick transfer register bank (byte addresses)
`define QTU_BASE 32'h0200_0000
`define QTU_OFS_CONFIG 8'h00
`define QTU_OFS_SOURCE 8'h04
`define QTU_OFS_COUNTS 8'h08
`define QTU_OFS_DEST 8'h0c
`define QTU_OFS_STRIDES 8'h10
`define QTU_SHADOW_OFS 8'h20
// parameter-set half-word fields (byte offsets)
`define QTU_PS_ELEM_STRIDE 8'h10
`define QTU_PS_FRAME_STRIDE 8'h12
`define QTU_PS_LINK 8'h14
`define QTU_PS_REFILL 8'h16
`define QTU_PS_BYTES 16'h0018
`define QTU_SETUP_SIZE 16'h0800
// option-word field positions
`define QTU_URG_HI 31
`define QTU_URG_LO 29
`define QTU_EW_HI 28
`define QTU_EW_LO 27
`define QTU_SDIM 26
`define QTU_SUM_HI 25
`define QTU_SUM_LO 24
`define QTU_DDIM 23
`define QTU_DUM_HI 22
`define QTU_DUM_LO 21
`define QTU_TCEN 20
`define QTU_TCC_HI 19
`define QTU_TCC_LO 16
`define QTU_TCCH_HI 14
`define QTU_TCCH_LO 13
`define QTU_ATEN 12
`define QTU_ALTERNATE_COMPLETION_CODE_HI 10
`define QTU_ALTERNATE_COMPLETION_CODE_LO 5
`define QTU_PRD 3
`define QTU_PWR 2
`define QTU_LINK 1
`define QTU_FSYNC 0
`define QTU_CFG_RESET 32'h0000_0000
`define QTU_FIFO_DEPTH 32
`endif

// *** verilog/qtu_pkg.sv ***
// types shared by the quick transfer unit and its option decoder
package qtu_pkg;
  typedef enum logic [2:0] {
    QTU_Q_URGENT = 3'h0,
    QTU_Q_HIGH = 3'h1,
    QTU_Q_MEDIUM = 3'h2,
    QTU_Q_LOW = 3'h3,
    QTU_Q_NONE = 3'h7
  } qtu_queue_t;

  typedef enum logic [1:0] {
    QTU_UPD_HOLD = 2'h0,
    QTU_UPD_INC = 2'h1,
    QTU_UPD_DEC = 2'h2,
    QTU_UPD_STRIDE = 2'h3
  } qtu_update_t;

  // decoded option word
  typedef struct packed {
    qtu_queue_t queue;
    logic [5:0] elem_bytes;
    logic source_dimension;
    qtu_update_t source_update_mode;
    logic destination_dimension;
    qtu_update_t destination_update_mode;
    logic completion_flag_enable;
    logic [5:0] completion_index;
    logic alternate_completion_enable;
    logic [5:0] alternate_completion_code;
    logic peripheral_read_mode;
    logic peripheral_write_mode;
    logic link_enable;
    logic frame_sync_select;
    logic valid;
  } qtu_opts_t;

  // one submitted transfer request
  typedef struct packed {
    qtu_opts_t opts;
    logic [31:0] source;
    logic [15:0] frame_count;
    logic [15:0] element_count;
    logic [31:0] dest;
    logic [15:0] frame_stride;
    logic [15:0] element_stride;
    logic whole_frame;
  } qtu_req_t;

  // cpu store
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic wr;
  } qtu_store_t;
endpackage

// *** verilog/qtu_fifo.sv ***
// parameterised request fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module qtu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** verilog/qtu_quick_transfer.sv ***
// quick transfer unit: option decode, register bank, request submission
// What this block does
// - extended urgency: 000..011 urgent to low
// - sixteen-channel urgency: 001 high, 010 second
// - element width 00 word, 01 half, 10 byte
// - source update: hold, inc, dec, stride
// - destination update uses same four encodings
// - completion enable gates pending bit setting
// - four-bit completion code picks pending bit
// - high code bits extend to six-bit index
// - alternate code flags intermediate completions
// - peripheral read and write mode bits
// - link enable reloads entry when exhausted
// - frame sync picks element or frame
// - element-sync reloads count from refill field
// - stride and link fields fixed word positions
// - quick unit: no reload, link bit reserved
// - hardware never alters quick registers
// - direct register writes configure only
// - shadow write configures and submits once
// - quick requests frame-synced, single request
// - channels request only on allowed triggers
`timescale 1ns/1ps
`default_nettype none
`include "qtu_map.svh"
module qtu_quick_transfer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic extended_mode,
  input var qtu_pkg::qtu_store_t store,
  output logic store_ready,
  output logic req_valid,
  input wire logic req_ready,
  output var qtu_pkg::qtu_req_t req,
  output logic [31:0] completion_pending_low,
  output logic [31:0] completion_pending_high,
  input wire logic done_valid,
  input wire logic done_final,
  input wire logic [5:0] done_index,
  input wire logic done_alt_en,
  input wire logic done_main_en,
  input wire logic [63:0] pending_clear,
  output logic rejected
);
  import qtu_pkg::*;

  // ********************************
  // option decode
  // ********************************
  function automatic qtu_opts_t decode_opts(input logic [31:0] w,
                                            input logic ext);
    qtu_opts_t o;
    logic [2:0] u;
    o = '0;
    u = w[`QTU_URG_HI:`QTU_URG_LO];
    o.valid = 1'b1;
    if (ext) begin
      unique case (u)
        3'h0: o.queue = QTU_Q_URGENT;
        3'h1: o.queue = QTU_Q_HIGH;
        3'h2: o.queue = QTU_Q_MEDIUM;
        3'h3: o.queue = QTU_Q_LOW;
        default: begin
          o.queue = QTU_Q_NONE;
          o.valid = 1'b0;
        end
      endcase
    end else begin
      // code 000 belongs to cache servicing only
      unique case (u)
        3'h1: o.queue = QTU_Q_HIGH;
        3'h2: o.queue = QTU_Q_MEDIUM;
        default: begin
          o.queue = QTU_Q_NONE;
          o.valid = 1'b0;
        end
      endcase
    end
    unique case (w[`QTU_EW_HI:`QTU_EW_LO])
      2'h0: o.elem_bytes = 6'h04;
      2'h1: o.elem_bytes = 6'h02;
      2'h2: o.elem_bytes = 6'h01;
      default: begin
        o.elem_bytes = 6'h00;
        o.valid = 1'b0;
      end
    endcase
    o.source_dimension = w[`QTU_SDIM];
    o.source_update_mode =
      qtu_update_t'(w[`QTU_SUM_HI:`QTU_SUM_LO]);
    o.destination_dimension = w[`QTU_DDIM];
    o.destination_update_mode =
      qtu_update_t'(w[`QTU_DUM_HI:`QTU_DUM_LO]);
    // stride mode has no meaning on a two-dimensional side
    if ((o.source_update_mode == QTU_UPD_STRIDE && o.source_dimension) ||
        (o.destination_update_mode == QTU_UPD_STRIDE &&
         o.destination_dimension)) begin
      o.valid = 1'b0;
    end
    o.completion_flag_enable = w[`QTU_TCEN];
    o.completion_index = {ext ? w[`QTU_TCCH_HI:`QTU_TCCH_LO] : 2'h0,
                          w[`QTU_TCC_HI:`QTU_TCC_LO]};
    o.alternate_completion_enable = ext & w[`QTU_ATEN];
    o.alternate_completion_code =
      ext ? w[`QTU_ALTERNATE_COMPLETION_CODE_HI:`QTU_ALTERNATE_COMPLETION_CODE_LO] : 6'h00;
    o.peripheral_read_mode = ext & w[`QTU_PRD];
    o.peripheral_write_mode = ext & w[`QTU_PWR];
    o.link_enable = w[`QTU_LINK];
    o.frame_sync_select = w[`QTU_FSYNC];
    return o;
  endfunction

  // ********************************
  // register bank
  // ********************************
  logic [31:0] quick_transfer_config;
  logic [31:0] quick_source_pointer;
  logic [31:0] quick_counts;
  logic [31:0] quick_dest_pointer;
  logic [31:0] quick_strides;
  logic in_bank;
  logic is_shadow;
  logic [7:0] ofs;
  logic [7:0] reg_ofs;
  logic legal_reg;
  logic take;

  assign ofs = store.addr[7:0];
  assign in_bank = (store.addr[31:8] == `QTU_BASE >> 8) &&
                   (ofs <= `QTU_SHADOW_OFS + `QTU_OFS_STRIDES) &&
                   (store.addr[1:0] == 2'h0);
  assign is_shadow = (ofs >= `QTU_SHADOW_OFS);
  assign reg_ofs = is_shadow ? (ofs - `QTU_SHADOW_OFS) : ofs;
  assign legal_reg = (reg_ofs <= `QTU_OFS_STRIDES);
  assign take = store.wr && in_bank && legal_reg && store_ready;

  // only the cpu updates these; transfers never write them back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quick_transfer_config <= `QTU_CFG_RESET;
      quick_source_pointer <= 32'h0;
      quick_counts <= 32'h0;
      quick_dest_pointer <= 32'h0;
      quick_strides <= 32'h0;
    end else if (take) begin
      unique case (reg_ofs)
        `QTU_OFS_CONFIG: begin
          // no link on the quick unit: bit stays zero
          quick_transfer_config <= store.data & ~(32'h1 << `QTU_LINK);
        end
        `QTU_OFS_SOURCE: quick_source_pointer <= store.data;
        `QTU_OFS_COUNTS: quick_counts <= store.data;
        `QTU_OFS_DEST: quick_dest_pointer <= store.data;
        default: quick_strides <= store.data;
      endcase
    end
  end

  // ********************************
  // submission
  // ********************************
  // a shadow write is submitted one cycle later, so it sees its own value
  logic submit_pend;
  qtu_opts_t cur_opts;
  qtu_req_t next_req;
  logic fifo_in_ready;
  logic fifo_out_valid;
  qtu_req_t fifo_out;

  assign cur_opts = decode_opts(quick_transfer_config, extended_mode);

  always_comb begin
    next_req = '0;
    next_req.opts = cur_opts;
    next_req.opts.link_enable = 1'b0;
    // always frame-synced, so the element count refill never applies
    next_req.opts.frame_sync_select = 1'b1;
    next_req.source = quick_source_pointer;
    next_req.frame_count = quick_counts[31:16];
    next_req.element_count = quick_counts[15:0];
    next_req.dest = quick_dest_pointer;
    next_req.frame_stride = quick_strides[31:16];
    next_req.element_stride = quick_strides[15:0];
    next_req.whole_frame = 1'b1;
    // 1-d to 1-d moves one frame only, whatever the frame count
    if (!cur_opts.source_dimension && !cur_opts.destination_dimension) begin
      next_req.frame_count = 16'h0;
    end
  end

  // stall stores while a submission is pending; back-pressure to cpu
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      submit_pend <= 1'b0;
      store_ready <= 1'b0;
      rejected <= 1'b0;
    end else begin
      rejected <= 1'b0;
      if (submit_pend) begin
        if (fifo_in_ready) begin
          submit_pend <= 1'b0;
          rejected <= !cur_opts.valid;
        end
      end else if (take && is_shadow) begin
        // a shadow store is the only trigger of this unit
        submit_pend <= 1'b1;
      end
      store_ready <= !(submit_pend && !fifo_in_ready) &&
                     !(take && is_shadow);
    end
  end

  qtu_fifo #(
    .WIDTH($bits(qtu_req_t)),
    .DEPTH(`QTU_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(submit_pend && cur_opts.valid),
    .in_ready(fifo_in_ready),
    .in_data(next_req),
    .out_valid(fifo_out_valid),
    .out_ready(req_ready && !req_valid),
    .out_data(fifo_out)
  );

  // output stage register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req <= '0;
    end else if (req_valid) begin
      if (req_ready) begin
        req_valid <= 1'b0;
      end
    end else if (fifo_out_valid && req_ready) begin
      req_valid <= 1'b1;
      req <= fifo_out;
    end
  end

  // ********************************
  // completion pending flags
  // ********************************
  function automatic logic [63:0] onehot6(input logic [5:0] i);
    return 64'h1 << i;
  endfunction

  logic [63:0] set_bits;
  assign set_bits = (done_valid && ((done_final && done_main_en) ||
                     (!done_final && done_alt_en)))
                    ? onehot6(done_index) : 64'h0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      completion_pending_low <= 32'h0;
      completion_pending_high <= 32'h0;
    end else begin
      completion_pending_low <= (completion_pending_low &
        ~pending_clear[31:0]) | set_bits[31:0];
      completion_pending_high <= (completion_pending_high &
        ~pending_clear[63:32]) | set_bits[63:32];
    end
  end
endmodule
`default_nettype wire

// *** test/qtu_quick_transfer_properties.sv ***
// port-level checks for the quick transfer unit
`timescale 1ns/1ps
`default_nettype none
`include "qtu_map.svh"
module qtu_checker (
  input wire logic clk,
  input wire logic rst_n,
  input var qtu_pkg::qtu_store_t store,
  input wire logic store_ready,
  input wire logic req_valid,
  input wire logic req_ready,
  input var qtu_pkg::qtu_req_t req,
  input wire logic [31:0] completion_pending_low,
  input wire logic [31:0] completion_pending_high,
  input wire logic done_valid,
  input wire logic done_final,
  input wire logic [5:0] done_index,
  input wire logic done_alt_en,
  input wire logic done_main_en,
  input wire logic [63:0] pending_clear,
  input wire logic rejected
);
  import qtu_pkg::*;
  logic [63:0] pend;
  logic shadow;
  logic hit;
  assign pend = {completion_pending_high, completion_pending_low};
  assign shadow = store.wr && store_ready && store.addr[1:0] == 2'h0 &&
    store.addr >= `QTU_BASE + 32'h20 && store.addr <= `QTU_BASE + 32'h30;
  assign hit = done_final ? done_main_en : done_alt_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_req_holds: assert property (
    req_valid && !req_ready |=> req_valid && $stable(req))
    else $error("request changed before acceptance");
  a_link_forced: assert property (
    req_valid |-> !req.opts.link_enable && req.whole_frame)
    else $error("request not whole frame or linked");
  a_main_flag: assert property (
    done_valid && done_final && done_main_en |=> pend[$past(done_index)])
    else $error("final completion flag missing");
  a_alt_flag: assert property (
    done_valid && !done_final && done_alt_en |=> pend[$past(done_index)])
    else $error("intermediate completion flag missing");
  a_flag_quiet: assert property (
    done_valid && !hit && !pend[done_index] |=> !pend[$past(done_index)])
    else $error("flag set while disabled");
  a_flag_sticky: assert property (
    1'b1 |=> (($past(pend) & ~$past(pending_clear) & ~pend) == 64'h0))
    else $error("flag lost without clear");
  a_shadow_pause: assert property (
    shadow |=> !store_ready)
    else $error("store accepted right after submit");
  a_reject_pulse: assert property (
    rejected |=> !rejected)
    else $error("reject longer than one cycle");
  c_accept: cover property (req_valid && req_ready);
  c_stall: cover property (req_valid && !req_ready);
  c_reject: cover property (rejected);
endmodule
bind qtu_quick_transfer qtu_checker qtu_checker_i (.clk, .rst_n, .store,
  .store_ready, .req_valid, .req_ready, .req, .completion_pending_low,
  .completion_pending_high, .done_valid, .done_final, .done_index,
  .done_alt_en, .done_main_en, .pending_clear, .rejected);
`default_nettype wire

// *** test/qtu_req_sink.sv ***
// downstream request consumer with prompt, slow and stalled modes
`timescale 1ns/1ps
`default_nettype none
module qtu_req_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic slow,
  output logic req_ready
);
  // slow mode toggles ready so held requests are exercised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= !stall && (!slow || !req_ready);
    end
  end
endmodule
`default_nettype wire

// *** test/qtu_quick_transfer_tb.sv ***
// self-checking bench for the quick transfer unit
`timescale 1ns/1ps
`default_nettype none
`include "qtu_map.svh"
module qtu_quick_transfer_tb;
  import qtu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic extended_mode = 1'b1;
  qtu_store_t store = '0;
  logic store_ready, req_valid, req_ready, rejected;
  qtu_req_t req, e, m;
  qtu_opts_t ro, mo;
  logic [31:0] completion_pending_low, completion_pending_high;
  logic done_valid = 1'b0, done_final = 1'b0;
  logic done_alt_en = 1'b0, done_main_en = 1'b0;
  logic [5:0] done_index = 6'h00;
  logic [63:0] pending_clear = '0;
  logic stall = 1'b0, slow = 1'b0;
  logic [15:0] seed = 16'h0bca;
  logic [31:0] cfg, src, cnt, dst, strd;
  int num_errors = 0, samples_checked = 0, rej_seen = 0, rej_exp = 0;
  int u16 [5] = '{0, 3, 1, 2, 5};
  qtu_req_t exp_q [$];
  always #12.5 clk = ~clk;
  qtu_quick_transfer qtu_quick_transfer_i (.clk, .rst_n, .extended_mode,
    .store, .store_ready, .req_valid, .req_ready, .req,
    .completion_pending_low, .completion_pending_high, .done_valid,
    .done_final, .done_index, .done_alt_en, .done_main_en,
    .pending_clear, .rejected);
  qtu_req_sink qtu_req_sink_i (.clk, .rst_n, .stall, .slow, .req_ready);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    for (int k = 0; k < 32; k++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      rnd[k] = seed[0];
    end
  endfunction
  function automatic logic [31:0] cw(input logic [2:0] u,
    input logic [1:0] w, input logic sd, input logic [1:0] sm,
    input logic dd, input logic [1:0] dm);
    logic [31:0] r;
    r = rnd();
    // link bit set on purpose: the unit must drop it; no link address
    return {u, w, sd, sm, dd, dm, r[20:2], 2'b10};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // store with a bounded wait on store_ready; model follows taken stores
  task automatic wr(input logic sh, input logic [7:0] ofs,
    input logic [31:0] d, input int lim, output bit ok);
    int n;
    logic [2:0] u;
    logic v;
    n = 0;
    @(posedge clk);
    #2;
    while (store_ready !== 1'b1 && n < lim) begin
      @(posedge clk);
      #2;
      n++;
    end
    ok = (n < lim);
    if (lim > 50) chk(ok, 1'b1);
    if (!ok) return;
    store = '{addr: `QTU_BASE + {24'h0, ofs} +
      (sh ? {24'h0, `QTU_SHADOW_OFS} : 32'h0), data: d, wr: 1'b1};
    @(posedge clk);
    #2;
    store.wr = 1'b0;
    case (ofs)
      8'h00: cfg = d;
      8'h04: src = d;
      8'h08: cnt = d;
      8'h0c: dst = d;
      default: strd = d;
    endcase
    if (!sh) return;
    u = cfg[31:29];
    v = (extended_mode ? u < 3'h4 : (u == 3'h1 || u == 3'h2)) &&
      cfg[28:27] != 2'h3 && !(cfg[25:24] == 2'h3 && cfg[26]) &&
      !(cfg[22:21] == 2'h3 && cfg[23]);
    if (!v) begin
      rej_exp++;
      return;
    end
    e = '0;
    e.opts.queue = qtu_queue_t'(u);
    e.opts.elem_bytes = 6'h04 >> cfg[28:27];
    e.opts.source_dimension = cfg[26];
    e.opts.source_update_mode = qtu_update_t'(cfg[25:24]);
    e.opts.destination_dimension = cfg[23];
    e.opts.destination_update_mode = qtu_update_t'(cfg[22:21]);
    e.opts.completion_flag_enable = cfg[20];
    e.opts.completion_index = {extended_mode ? cfg[14:13] : 2'h0, cfg[19:16]};
    e.opts.alternate_completion_enable = extended_mode & cfg[12];
    e.opts.alternate_completion_code = extended_mode ? cfg[10:5] : 6'h00;
    e.opts.peripheral_read_mode = extended_mode & cfg[3];
    e.opts.peripheral_write_mode = extended_mode & cfg[2];
    e.opts.frame_sync_select = 1'b1;
    e.opts.valid = 1'b1;
    e.whole_frame = 1'b1;
    e.source = src;
    e.dest = dst;
    e.frame_count = (cfg[26] | cfg[23]) ? cnt[31:16] : 16'h0000;
    e.element_count = cnt[15:0];
    e.frame_stride = strd[31:16];
    e.element_stride = strd[15:0];
    exp_q.push_back(e);
  endtask
  always @(posedge clk) begin
    if (rst_n && rejected === 1'b1) rej_seen++;
    if (rst_n && req_valid === 1'b1 && req_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b1, 1'b0);
      else begin
        m = exp_q.pop_front();
        ro = req.opts;
        mo = m.opts;
        // opts packs queue, width, update, completion, then mode bits
        chk(ro[33:25], mo[33:25]);
        chk(ro[24:19], mo[24:19]);
        chk(ro[18:5], mo[18:5]);
        chk(ro[4:0], mo[4:0]);
        chk({req.source, req.dest}, {m.source, m.dest});
        chk({req.frame_count, req.element_count, req.whole_frame},
          {m.frame_count, m.element_count, m.whole_frame});
        chk({req.frame_stride, req.element_stride},
          {m.frame_stride, m.element_stride});
      end
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    bit ok;
    int k, n;
    logic [31:0] d;
    repeat (12) @(posedge clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      for (int r = 1; r < 5; r++) wr(1'b0, 8'(r * 4), rnd(), 200, ok);
      wr(1'b1, 8'h00, cw(3'(i), 2'(i % 3), i == 1, 2'(i), i == 2,
        2'(3 - i)), 200, ok);
      wr(1'b1, i[0] ? 8'h10 : 8'h04, rnd(), 200, ok);
    end
    $display("encoding test done");
    for (int i = 0; i < 10; i++) begin
      extended_mode = (i < 5);
      wr(1'b1, 8'h00, cw(i < 4 ? 3'(4 + i) : (i == 4 ? 3'h1 : 3'(u16[i - 5])),
        i == 4 ? 2'h3 : 2'(i % 3), 1'b0, 2'h1, 1'b0, 2'h1), 200, ok);
    end
    extended_mode = 1'b1;
    wr(1'b1, 8'h00, cw(3'h1, 2'h0, 1'b1, 2'h3, 1'b0, 2'h0), 200, ok);
    repeat (20) @(posedge clk);
    chk(64'(rej_seen), 64'(rej_exp));
    $display("reserved code test done");
    // a valid setup, or every shadow store below would be dropped
    wr(1'b0, 8'h00, cw(3'h2, 2'h0, 1'b1, 2'h1, 1'b0, 2'h3), 200, ok);
    #2 stall = 1'b1;
    k = 0;
    ok = 1'b1;
    while (ok && k < 40) begin
      wr(1'b1, 8'h04, rnd(), 20, ok);
      k++;
    end
    chk(k >= 33 && k < 40, 1'b1);
    stall = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(64'(exp_q.size()), 64'h0);
    $display("buffer test done");
    for (int j = 0; j < 8; j++) begin
      d = rnd();
      @(posedge clk);
      #2 pending_clear = '1;
      @(posedge clk);
      #2 pending_clear = '0;
      {done_valid, done_index, done_final} = {1'b1, d[5:0], j[0]};
      {done_main_en, done_alt_en} = {j[1], j[2]};
      @(posedge clk);
      #2 done_valid = 1'b0;
      @(posedge clk);
      #2 chk({completion_pending_high, completion_pending_low},
        (j[0] ? j[1] : j[2]) ? 64'h1 << d[5:0] :
        64'h0);
    end
    $display("completion test done");
    close_out;
  end
  initial begin
    #2000000;
    num_errors++;
    close_out;
  end
endmodule
`default_nettype wire
